/* bench/eal_host.sv */
// Host model that drives the register port of the energy block
`timescale 1ns/10ps
`default_nettype none

module eal_host (
	// Clock
	input  wire logic                     clk_sys,
	// Register port request
	output var eal_pkg::eal_reg_req_type  reg_req
);
	import eal_pkg::*;

	// One access: raise after an edge, hold through the taking edge, then drop
	task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] data);
		@(posedge clk_sys);
		#1;
		reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: data};
		@(posedge clk_sys);
		#1;
		// Idle fields flip so stale values are never mistaken for live ones
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask

	// Quiet port from time zero
	initial begin
		reg_req = '0;
	end
endmodule

`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the energy accumulation block
`timescale 1ns/10ps
`default_nettype none
`include "eal_map.svh"

module testbench;
	import eal_pkg::*;

	localparam int DIV = 16;

	logic             clk_sys = 1'b0;
	logic             rst_n = 1'b0;
	eal_phase_in_type ph;
	eal_phase_in_type phc;
	eal_reg_req_type  req;
	logic [31:0]      rdata;
	logic [31:0]      pulse;
	logic             rvalid;
	logic             irq_n;
	logic [63:0]      exp_q[$];
	logic [63:0]      e;
	logic             sgn = 1'b0;
	int               cnt = 0;
	int               failures = 0;
	int               checks = 0;
	int               seed = 7481;
	int               n;

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	eal_top #(.SAMPLE_DIV(DIV)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.phase_a(ph), .phase_b(ph), .phase_c(phc),
		.reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.pulse_frequency_output(pulse), .interrupt_pin_0_n(irq_n)
	);

	eal_host u_host (
		.clk_sys(clk_sys),
		.reg_req(req)
	);

	////////////////////////////////////////////////////////////////////////////////
	// One sign flip per sample period, so every tick sees a crossing
	always @(posedge clk_sys) begin
		cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
		if (cnt == 0) begin
			sgn <= #1 ~sgn;
		end
	end

	// Product v*i stays positive: 2^32, so 256 per sample
	assign ph = sgn ? eal_phase_in_type'{v: -24'sh100000, i: -24'sh001000, iq: -24'sh00103f}
	                : eal_phase_in_type'{v: 24'sh100000, i: 24'sh001000, iq: 24'sh00103f};

	// Phase C draws twice the current, so a phase mix-up shows in the results
	assign phc = eal_phase_in_type'{v: ph.v, i: 24'(ph.i <<< 1), iq: ph.iq};

	////////////////////////////////////////////////////////////////////////////////
	// Compare under a care mask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
		checks++;
		if ((got & care) !== (exp & care)) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Read answers are matched against the oldest note
	always @(posedge clk_sys) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				checks++;
				failures++;
				$display("[FAIL] %0t got %h expected %h", $time, rdata, 32'h0);
			end else begin
				e = exp_q.pop_front();
				check(rdata, e[63:32], e[31:0]);
			end
		end
	end

	task automatic rd(input logic [3:0] addr, input logic [31:0] exp, input logic [31:0] care);
		exp_q.push_back({exp, care});
		u_host.access(1'b0, addr, 32'h0);
	endtask

	task automatic wr(input logic [3:0] addr, input logic [31:0] data);
		u_host.access(1'b1, addr, data);
	endtask

	// Bounded wait for the pin to fall
	task automatic wait_done;
		int k;
		k = 0;
		while (irq_n !== 1'b0 && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		#1;
		check({31'h0, irq_n}, 32'h0, 32'h1);
	endtask

	task automatic print_verdict;
		if (exp_q.size() != 0) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, exp_q.size(), 0);
		end
		if (failures == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int mult [4];
		mult = '{1, 0, -2, -1};
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		// Reset values, then an unmapped index
		for (int a = 0; a < 5; a++) begin
			rd(4'(a), 32'h0, '1);
		end
		rd(4'hf, 32'h0, '1);
		// Field widths on readback
		wr(`EAL_IDX_ACC_MODE, 32'hffff_ffff);
		rd(`EAL_IDX_ACC_MODE, 32'h0000_00ff, '1);
		wr(`EAL_IDX_HALF_CYCLES, 32'hffff_ffff);
		rd(`EAL_IDX_HALF_CYCLES, 32'h0000_ffff, '1);
		wr(`EAL_IDX_INTERRUPT_MASK_0, 32'h20);
		rd(`EAL_IDX_INTERRUPT_MASK_0, 32'h20, '1);
		n = 4 + ($random(seed) & 7);
		// One crossing phase at a time (A, B, C, A), clear-on-read kept low
		for (int m = 0; m < 4; m++) begin
			wr(`EAL_IDX_LC_MODE, 32'h01 | (32'h20 >> (m % 3)));
			wr(`EAL_IDX_ACC_MODE, 32'(m << 4));
			wr(`EAL_IDX_HALF_CYCLES, 32'(n));
			wr(`EAL_IDX_INTERRUPT_STATUS_0, 32'h20);
			repeat (2) @(posedge clk_sys);
			check({31'h0, irq_n}, 32'h1, 32'h1);
			wait_done();
			wr(`EAL_IDX_INTERRUPT_STATUS_0, 32'h20);
			wait_done();
			rd(`EAL_IDX_INTERRUPT_STATUS_0, 32'h20, '1);
			rd(`EAL_IDX_ENERGY_A, 32'(n * 256), '1);
			rd(`EAL_IDX_ENERGY_B, 32'(n * 256 * mult[m]), '1);
			rd(`EAL_IDX_ENERGY_C, 32'(n * 512), '1);
		end
		// Wiring 11 gives increments +256, -256, +512
		repeat (40) @(posedge clk_sys);
		check(pulse, 32'h200, '1);
		wr(`EAL_IDX_ACC_MODE, 32'h31);
		repeat (40) @(posedge clk_sys);
		check(pulse, 32'h400, '1);
		// Filter settles within a few LSB of 256
		repeat (5000) @(posedge clk_sys);
		rd(`EAL_IDX_VAR_A, 32'h100, 32'hffff_fffc);
		// Normal mode with clear-on-read: the next read sees at most one increment
		wr(`EAL_IDX_LC_MODE, 32'h40);
		rd(`EAL_IDX_ENERGY_A, 32'h0, 32'h0);
		rd(`EAL_IDX_ENERGY_A, 32'h0, 32'hffff_feff);
		repeat (4) @(posedge clk_sys);
		print_verdict();
	end

	// Hang guard, well past the expected run length
	initial begin
		#300000;
		check(32'h0, 32'h1, '1);
		print_verdict();
	end
endmodule

`default_nettype wire

/* rtl/eal_map.svh */
// Register indices, field positions, reset values and timing counts of the energy block
`ifndef EAL_MAP_SVH
`define EAL_MAP_SVH

// Register indices on the register port
`define EAL_IDX_ACC_MODE      4'h0
`define EAL_IDX_LC_MODE       4'h1
`define EAL_IDX_HALF_CYCLES   4'h2
`define EAL_IDX_INTERRUPT_STATUS_0       4'h3
`define EAL_IDX_INTERRUPT_MASK_0         4'h4
`define EAL_IDX_ENERGY_A      4'h5
`define EAL_IDX_ENERGY_B      4'h6
`define EAL_IDX_ENERGY_C      4'h7
`define EAL_IDX_VAR_A         4'h8
`define EAL_IDX_VAR_B         4'h9
`define EAL_IDX_VAR_C         4'ha

// Field positions
`define EAL_WIRING_LSB        4
`define EAL_PULSE_LSB         0
`define EAL_LC_EN_BIT         0
`define EAL_CLR_READ_BIT      6
`define EAL_ZX_A_BIT          5
`define EAL_ZX_B_BIT          4
`define EAL_ZX_C_BIT          3
`define EAL_DONE_BIT          5

// Reset values
`define EAL_ACC_MODE_RST      8'h00
`define EAL_LC_MODE_RST       8'h00
`define EAL_HALF_CYCLES_RST   16'h0000
`define EAL_INTERRUPT_MASK_0_RST         32'h0000_0000

// Timing: 125 us sample period at a 10 ns clock
`define EAL_SAMPLE_PERIOD_NS  125000
`define EAL_CLK_PERIOD_NS     10
`define EAL_SAMPLE_CYCLES     (`EAL_SAMPLE_PERIOD_NS / `EAL_CLK_PERIOD_NS)

// Signal path scaling
`define EAL_LPF_SHIFT         6
`define EAL_VAR_SCALE_SHIFT   4

`endif

/* rtl/eal_phase.sv */
// One phase: active product, filtered reactive power and zero-crossing detect
`timescale 1ns/10ps
`default_nettype none
`include "eal_map.svh"

module eal_phase (
	// Clock and reset
	input  wire logic           clk_sys,
	input  wire logic           rst_n,
	// Samples
	input  wire logic           tick,
	input  wire eal_pkg::eal_sample_type v,
	input  wire eal_pkg::eal_sample_type v_act,
	input  wire eal_pkg::eal_sample_type i,
	input  wire eal_pkg::eal_sample_type iq,
	// Results
	output logic signed [23:0]  p_q,
	output logic [23:0]         var_q,
	output logic                zx_q,
	output logic                valid_q
);
	import eal_pkg::*;

	logic signed [47:0] prod_p;
	logic signed [47:0] prod_q;
	logic signed [27:0] q_inst;
	logic signed [28:0] lpf_diff;
	logic signed [27:0] lpf_q;
	logic signed [27:0] lpf_d;
	logic signed [23:0] p_d;
	logic               sign_q;
	logic               sign_d;
	logic               zx_d;
	logic               valid_d;

	////////////////////////////////////////////////////////////////////////
	// Next values, computed once per sample tick
	always_comb begin
		prod_p   = v_act * i;
		prod_q   = v * iq;     // Voltage times quadrature current
		q_inst   = prod_q[47:20];
		lpf_diff = q_inst - lpf_q;
		p_d      = p_q;
		lpf_d    = lpf_q;
		sign_d   = sign_q;
		zx_d     = 1'b0;
		valid_d  = tick;
		if (tick) begin
			p_d    = prod_p[47:24];
			// Slow one-pole filter keeps only the dc term
			lpf_d  = lpf_q + 28'(lpf_diff >>> `EAL_LPF_SHIFT);
			sign_d = v[23];
			// Both edges count, so each event is one half cycle
			zx_d   = (v[23] != sign_q);
		end
	end

	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			p_q     <= 24'sh000000;
			lpf_q   <= 28'sh0000000;
			sign_q  <= 1'b0;
			zx_q    <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			p_q     <= p_d;
			lpf_q   <= lpf_d;
			sign_q  <= sign_d;
			zx_q    <= zx_d;
			valid_q <= valid_d;
		end
	end

	// Scaled down by 2^4 for the 24-bit register
	assign var_q = lpf_q[27:`EAL_VAR_SCALE_SHIFT];

endmodule
`default_nettype wire

/* rtl/eal_pkg.sv */
// Types shared by the energy accumulation block
package eal_pkg;

	typedef logic signed [23:0] eal_sample_type;

	// One phase worth of DSP samples
	typedef struct packed {
		eal_sample_type v;
		eal_sample_type i;
		eal_sample_type iq;
	} eal_phase_in_type;

	// One register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} eal_reg_req_type;

	// Wiring configuration encodings
	typedef enum logic [1:0] {
		EAL_WIRE_OWN     = 2'b00,
		EAL_WIRE_B_ZERO  = 2'b01,
		EAL_WIRE_B_NEG_AC = 2'b10,
		EAL_WIRE_B_NEG_A = 2'b11
	} eal_wiring_type;

endpackage

/* rtl/eal_top.sv */
// Three-phase active energy accumulation, line-cycle mode and reactive power registers
`timescale 1ns/10ps
`default_nettype none
`include "eal_map.svh"

module eal_top #(
	parameter int SAMPLE_DIV = `EAL_SAMPLE_CYCLES
) (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// Phase samples from the DSP front end
	input  wire eal_pkg::eal_phase_in_type phase_a,
	input  wire eal_pkg::eal_phase_in_type phase_b,
	input  wire eal_pkg::eal_phase_in_type phase_c,
	// Register port
	input  wire eal_pkg::eal_reg_req_type  reg_req,
	output logic [31:0]                    reg_rdata,
	output logic                           reg_rvalid,
	// Outputs
	output logic [31:0]                    pulse_frequency_output,
	output logic                           interrupt_pin_0_n
);
	import eal_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0]        div_q, div_d;
	logic               tick;
	logic [7:0]         acc_mode_q, acc_mode_d;
	logic [7:0]         lc_mode_q, lc_mode_d;
	logic [15:0]        half_cycle_count_q, half_cycle_count_d;
	logic [31:0]        mask_q, mask_d;
	logic               done_q, done_d;
	logic [15:0]        zx_cnt_q, zx_cnt_d;
	logic [31:0]        acc_q [3];
	logic [31:0]        acc_d [3];
	logic [31:0]        energy_q [3];
	logic [31:0]        energy_d [3];
	logic [31:0]        rdata_d;
	logic               rvalid_d;
	logic [31:0]        pulse_d;
	eal_sample_type     vb_act;
	eal_wiring_type     wiring_select;
	logic [1:0]         pulse_sign_mode;
	logic               line_cycle_enable;
	logic               clear_on_read;
	logic [2:0]         crossing_phase_select;
	logic signed [23:0] p_raw [3];
	logic [23:0]        var_w [3];
	logic [2:0]         zx_w;
	logic [2:0]         valid_w;
	logic [31:0]        inc [3];
	logic [1:0]         zx_add;
	logic [16:0]        zx_sum;
	logic               period_end;
	logic               count_wr;
	logic               status_clr;
	logic [31:0]        abs_p [3];

	// Field decode
	assign wiring_select         = eal_wiring_type'(acc_mode_q[`EAL_WIRING_LSB +: 2]);
	assign pulse_sign_mode       = acc_mode_q[`EAL_PULSE_LSB +: 2];
	assign line_cycle_enable     = lc_mode_q[`EAL_LC_EN_BIT];
	assign clear_on_read         = lc_mode_q[`EAL_CLR_READ_BIT];
	assign crossing_phase_select = {lc_mode_q[`EAL_ZX_A_BIT], lc_mode_q[`EAL_ZX_B_BIT],
		lc_mode_q[`EAL_ZX_C_BIT]};

	////////////////////////////////////////////////////////////////////////
	// Sample rate divider
	always_comb begin
		tick  = (div_q == 16'(SAMPLE_DIV - 1));
		div_d = tick ? 16'h0000 : div_q + 16'h0001;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase B voltage for the active path; reactive and crossings use the real one
	always_comb begin
		unique case (wiring_select)
			EAL_WIRE_OWN:      vb_act = phase_b.v;
			EAL_WIRE_B_ZERO:   vb_act = phase_b.v;
			EAL_WIRE_B_NEG_AC: vb_act = 24'(-phase_a.v - phase_c.v);
			EAL_WIRE_B_NEG_A:  vb_act = 24'(-phase_a.v);
		endcase
	end

	// Per-phase channels
	eal_phase u_phase_a (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (tick),
		.v       (phase_a.v),
		.v_act   (phase_a.v),
		.i       (phase_a.i),
		.iq      (phase_a.iq),
		.p_q     (p_raw[0]),
		.var_q   (var_w[0]),
		.zx_q    (zx_w[2]),
		.valid_q (valid_w[0])
	);

	eal_phase u_phase_b (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (tick),
		.v       (phase_b.v),
		.v_act   (vb_act),
		.i       (phase_b.i),
		.iq      (phase_b.iq),
		.p_q     (p_raw[1]),
		.var_q   (var_w[1]),
		.zx_q    (zx_w[1]),
		.valid_q (valid_w[1])
	);

	eal_phase u_phase_c (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (tick),
		.v       (phase_c.v),
		.v_act   (phase_c.v),
		.i       (phase_c.i),
		.iq      (phase_c.iq),
		.p_q     (p_raw[2]),
		.var_q   (var_w[2]),
		.zx_q    (zx_w[0]),
		.valid_q (valid_w[2])
	);

	////////////////////////////////////////////////////////////////////////
	// Energy increments, signed; B forced to zero in three-wire delta
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			inc[k]   = valid_w[k] ? {{8{p_raw[k][23]}}, p_raw[k]} : 32'h0000_0000;
			abs_p[k] = p_raw[k][23] ? 32'(-inc[k]) : inc[k];
		end
		if (wiring_select == EAL_WIRE_B_ZERO) begin
			inc[1]   = 32'h0000_0000;
			abs_p[1] = 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Zero-crossing counter, free running whatever the mode
	always_comb begin
		count_wr   = reg_req.wr && (reg_req.addr == `EAL_IDX_HALF_CYCLES);
		zx_add     = 2'(zx_w[2] & crossing_phase_select[2])
			+ 2'(zx_w[1] & crossing_phase_select[1])
			+ 2'(zx_w[0] & crossing_phase_select[0]);
		zx_sum     = {1'b0, zx_cnt_q} + {15'h0000, zx_add};
		// A zero target never ends a period
		period_end = (half_cycle_count_q != 16'h0000)
			&& (zx_sum >= {1'b0, half_cycle_count_q});
		if (count_wr && line_cycle_enable) begin
			zx_cnt_d = 16'h0000;
		end else if (period_end) begin
			zx_cnt_d = 16'h0000;
		end else begin
			zx_cnt_d = zx_sum[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Internal accumulators and energy registers, one signal path for both modes
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			// A count write in line-cycle mode restarts the period, so old energy goes
			acc_d[k]    = (period_end || (count_wr && line_cycle_enable)) ? 32'h0000_0000
				: acc_q[k] + inc[k];
			energy_d[k] = energy_q[k];
			if (line_cycle_enable) begin
				if (period_end) begin
					energy_d[k] = acc_q[k] + inc[k];
				end
			end else if (reg_req.rd && clear_on_read
				&& (reg_req.addr == 4'(`EAL_IDX_ENERGY_A + k))) begin
				// Cleared by the read, the same-cycle increment is kept
				energy_d[k] = inc[k];
			end else begin
				energy_d[k] = energy_q[k] + inc[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers and completion flag
	always_comb begin
		acc_mode_d         = acc_mode_q;
		lc_mode_d          = lc_mode_q;
		half_cycle_count_d = half_cycle_count_q;
		mask_d             = mask_q;
		status_clr         = reg_req.wr && (reg_req.addr == `EAL_IDX_INTERRUPT_STATUS_0)
			&& reg_req.wdata[`EAL_DONE_BIT];
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`EAL_IDX_ACC_MODE:    acc_mode_d = reg_req.wdata[7:0];
				`EAL_IDX_LC_MODE:     lc_mode_d = reg_req.wdata[7:0];
				`EAL_IDX_HALF_CYCLES: half_cycle_count_d = reg_req.wdata[15:0];
				`EAL_IDX_INTERRUPT_MASK_0:       mask_d = reg_req.wdata;
				default:              ;
			endcase
		end
		// Set wins over a same-cycle clear so no period end is lost
		done_d = (period_end && line_cycle_enable) || (done_q && !status_clr);
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, registered one cycle after the request
	always_comb begin
		rvalid_d = reg_req.rd;
		rdata_d  = 32'h0000_0000;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`EAL_IDX_ACC_MODE:    rdata_d = {24'h000000, acc_mode_q};
				`EAL_IDX_LC_MODE:     rdata_d = {24'h000000, lc_mode_q};
				`EAL_IDX_HALF_CYCLES: rdata_d = {16'h0000, half_cycle_count_q};
				`EAL_IDX_INTERRUPT_STATUS_0:     rdata_d = 32'(done_q) << `EAL_DONE_BIT;
				`EAL_IDX_INTERRUPT_MASK_0:       rdata_d = mask_q;
				`EAL_IDX_ENERGY_A:    rdata_d = energy_q[0];
				`EAL_IDX_ENERGY_B:    rdata_d = energy_q[1];
				`EAL_IDX_ENERGY_C:    rdata_d = energy_q[2];
				`EAL_IDX_VAR_A:       rdata_d = {8'h00, var_w[0]};
				`EAL_IDX_VAR_B:       rdata_d = {8'h00, var_w[1]};
				`EAL_IDX_VAR_C:       rdata_d = {8'h00, var_w[2]};
				default:              rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Pulse output feed: signed sum, or sum of magnitudes in absolute mode
	always_comb begin
		pulse_d = pulse_frequency_output;
		if (valid_w[0]) begin
			if (pulse_sign_mode == 2'b01) begin
				pulse_d = abs_p[0] + abs_p[1] + abs_p[2];
			end else begin
				pulse_d = inc[0] + inc[1] + inc[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			acc_mode_q             <= `EAL_ACC_MODE_RST;
			lc_mode_q              <= `EAL_LC_MODE_RST;
			half_cycle_count_q     <= `EAL_HALF_CYCLES_RST;
			mask_q                 <= `EAL_INTERRUPT_MASK_0_RST;
			done_q                 <= 1'b0;
			zx_cnt_q               <= 16'h0000;
			reg_rdata              <= 32'h0000_0000;
			reg_rvalid             <= 1'b0;
			pulse_frequency_output <= 32'h0000_0000;
			for (int k = 0; k < 3; k++) begin
				acc_q[k]    <= 32'h0000_0000;
				energy_q[k] <= 32'h0000_0000;
			end
		end else begin
			acc_mode_q             <= acc_mode_d;
			lc_mode_q              <= lc_mode_d;
			half_cycle_count_q     <= half_cycle_count_d;
			mask_q                 <= mask_d;
			done_q                 <= done_d;
			zx_cnt_q               <= zx_cnt_d;
			reg_rdata              <= rdata_d;
			reg_rvalid             <= rvalid_d;
			pulse_frequency_output <= pulse_d;
			for (int k = 0; k < 3; k++) begin
				acc_q[k]    <= acc_d[k];
				energy_q[k] <= energy_d[k];
			end
		end
	end

	// Active-low interrupt pin from the masked flag
	assign interrupt_pin_0_n = !(done_q && mask_q[`EAL_DONE_BIT]);

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_tick_spacing;
		@(posedge clk_sys) disable iff (!rst_n) tick |=> !tick [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("sample ticks too close");

	property p_done_set;
		@(posedge clk_sys) disable iff (!rst_n) (period_end && line_cycle_enable) |=> done_q;
	endproperty
	a_done_set: assert property (p_done_set) else $error("period end did not set flag");

	property p_irq_low;
		@(posedge clk_sys) disable iff (!rst_n)
			(period_end && line_cycle_enable && mask_q[`EAL_DONE_BIT] && !reg_req.wr)
			|=> !interrupt_pin_0_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt pin not driven low");

	property p_done_clear;
		@(posedge clk_sys) disable iff (!rst_n)
			(status_clr && !(period_end && line_cycle_enable)) |=> !done_q && interrupt_pin_0_n;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("flag not cleared by write one");

	property p_no_done_off;
		@(posedge clk_sys) disable iff (!rst_n) (!line_cycle_enable && !done_q) |=> !done_q;
	endproperty
	a_no_done_off: assert property (p_no_done_off) else $error("flag set outside line-cycle mode");

	property p_hold_energy;
		@(posedge clk_sys) disable iff (!rst_n)
			(line_cycle_enable && !period_end) |=> $stable(energy_q[0]) && $stable(energy_q[2]);
	endproperty
	a_hold_energy: assert property (p_hold_energy) else $error("energy moved inside a period");

	property p_count_reset;
		@(posedge clk_sys) disable iff (!rst_n) (count_wr && line_cycle_enable) |=> zx_cnt_q == 16'h0000;
	endproperty
	a_count_reset: assert property (p_count_reset) else $error("count write did not reset counter");

	property p_count_one;
		@(posedge clk_sys) disable iff (!rst_n)
			(zx_w == 3'b100 && crossing_phase_select[2] && !period_end && !count_wr)
			|=> zx_cnt_q == $past(zx_cnt_q) + 16'h0001;
	endproperty
	a_count_one: assert property (p_count_one) else $error("crossing did not add exactly one");

	property p_b_zero;
		@(posedge clk_sys) disable iff (!rst_n)
			(wiring_select == EAL_WIRE_B_ZERO && !line_cycle_enable && !reg_req.rd)
			|=> $stable(energy_q[1]);
	endproperty
	a_b_zero: assert property (p_b_zero) else $error("phase B energy moved in three-wire mode");

	property p_clear_read;
		@(posedge clk_sys) disable iff (!rst_n)
			(reg_req.rd && reg_req.addr == `EAL_IDX_ENERGY_A && clear_on_read
			&& !line_cycle_enable && !valid_w[0]) |=> energy_q[0] == 32'h0000_0000;
	endproperty
	a_clear_read: assert property (p_clear_read) else $error("energy not cleared after read");

endmodule
`default_nettype wire
